/* logic/tmra_map.vh */
// Purpose: register indices, field positions, reset values for the timer block
// Assumes: register byte address is four times the index
// Notes: definitions only
`ifndef TMRA_MAP_VH
`define TMRA_MAP_VH

// Register indices (byte address = index * 4)
`define TMRA_IDX_GLOBAL_CTRL 10'h00b
`define TMRA_IDX_FLAGS_ONE 10'h00c
`define TMRA_IDX_FLAGS_TWO 10'h00d
`define TMRA_IDX_COUNT_LOW 10'h00e
`define TMRA_IDX_COUNT_HIGH 10'h00f
`define TMRA_IDX_TIMER_CTRL 10'h010
`define TMRA_IDX_CONV_RESULT 10'h01e
`define TMRA_IDX_CONV_CTRL 10'h01f
`define TMRA_IDX_ENABLES_ONE 10'h08c
`define TMRA_IDX_ENABLES_TWO 10'h08d

// Reset values
`define TMRA_RST_BYTE 8'h00

// Timer control fields
`define TMRA_TC_ON 0
`define TMRA_TC_EXT_SRC 1
`define TMRA_TC_PS_LO 4
`define TMRA_TC_PS_HI 5
`define TMRA_TC_MASK 8'h3f

// Converter control fields
`define TMRA_CC_ENABLE 0
`define TMRA_CC_GO 2
`define TMRA_CC_MASK 8'hfd

// Flag and enable bit positions
`define TMRA_F1_OVERFLOW 0
`define TMRA_F1_CMP_FIRST 2
`define TMRA_F1_CONV_DONE 6
`define TMRA_F2_CMP_SECOND 0
`define TMRA_F2_MASK 8'h01
`define TMRA_GC_GLOBAL 7
`define TMRA_GC_PERIPH 6

// Special event trigger compare mode
`define TMRA_MODE_SPECIAL 4'hb

`endif

/* logic/tmra_prescale.v */
// Purpose: timer prescaler, 1:1 to 1:8
// Assumes: tick_in is a one-cycle pulse
// Notes: clear wins over counting
`timescale 1ns/1ns
module tmra_prescale (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Control
   input wire clear,
   input wire tick_in,
   input wire [1:0] ratio,
   // Prescaled tick
   output wire tick_out
);
   reg [2:0] count;
   wire [2:0] mask;

   // Ratio 0..3 gives divide by 1, 2, 4, 8
   assign mask = (ratio == 2'h0) ? 3'h0 : (ratio == 2'h1) ? 3'h1 :
                 (ratio == 2'h2) ? 3'h3 : 3'h7;
   assign tick_out = tick_in & ((count & mask) == mask) & ~clear;

   // Prescale counter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 3'h0;
      end else if (clear) begin
         count <= 3'h0;
      end else if (tick_in) begin
         count <= count + 3'h1;
      end
   end
endmodule // tmra_prescale

/* logic/tmra_trigger.v */
// Purpose: special event trigger decode for both compare units
// Assumes: match inputs are one-cycle pulses from the compare units
// Notes: purely combinational, registered by the caller
`timescale 1ns/1ns
`include "tmra_map.vh"
module tmra_trigger (
   // Compare unit side
   input wire [1:0] cmp_match,
   input wire [7:0] cmp_mode,
   // Converter enable
   input wire conv_enable,
   // Decoded events
   output wire [1:0] special,
   output wire conv_start
);
   genvar i;
   // One decoder per compare unit
   generate
      for (i = 0; i < 2; i = i + 1) begin : g_unit
         assign special[i] = cmp_match[i] &
            (cmp_mode[4*i+3:4*i] == `TMRA_MODE_SPECIAL);
      end
   endgenerate

   // Only the second unit may start a conversion
   assign conv_start = special[1] & conv_enable;
endmodule // tmra_trigger

/* logic/tmra_top.v */
// Purpose: 16-bit timer with reset handling and converter start trigger
// Assumes: APB slave, one clock, inputs synchronous to pclk
// Notes: presetn is the power-on / brown-out reset; other_reset the rest
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`include "tmra_map.vh"
module tmra_top (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   input wire other_reset,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // External timer clock pin
   input wire ext_clk_pin,
   // Compare units
   input wire cmp_first_match,
   input wire [3:0] cmp_first_mode,
   input wire cmp_second_match,
   input wire [3:0] cmp_second_mode,
   // Converter
   input wire conv_done,
   input wire [7:0] conv_data,
   output reg conv_start,
   output reg conv_enable,
   output reg [2:0] conv_channel,
   output reg [1:0] conv_clock_sel,
   // Interrupt
   output reg irq
);
   // Register storage
   reg [7:0] global_interrupt_control;
   reg [7:0] peripheral_flags_one;
   reg [7:0] peripheral_flags_two;
   reg [7:0] count_low_byte;
   reg [7:0] count_high_byte;
   reg [7:0] timer_control;
   reg [7:0] conversion_result;
   reg [7:0] converter_control;
   reg [7:0] peripheral_enables_one;
   reg [7:0] peripheral_enables_two;
   reg ext_clk_q;

   // Bus decode
   wire [9:0] idx;
   wire access;
   wire done;
   wire wr;
   wire rd;
   wire mapped;
   reg [7:0] read_byte;

   // Timer datapath
   wire wr_low;
   wire wr_high;
   wire count_wr;
   wire src_tick;
   wire pre_tick;
   wire [1:0] special;
   wire start_req;
   wire trig_reset;
   wire [15:0] count;
   wire [16:0] count_inc;

   // Next values
   reg [7:0] next_flags_one;
   reg [7:0] next_flags_two;
   reg [7:0] next_conv_ctrl;

   assign idx = paddr[11:2];
   assign access = psel & penable;
   assign done = access & pready;
   assign wr = done & pwrite & ~pslverr;
   assign rd = done & ~pwrite & ~pslverr;

   // Address map
   assign mapped = (paddr[1:0] == 2'h0) &&
      (idx == `TMRA_IDX_GLOBAL_CTRL || idx == `TMRA_IDX_FLAGS_ONE ||
       idx == `TMRA_IDX_FLAGS_TWO || idx == `TMRA_IDX_COUNT_LOW ||
       idx == `TMRA_IDX_COUNT_HIGH || idx == `TMRA_IDX_TIMER_CTRL ||
       idx == `TMRA_IDX_CONV_RESULT || idx == `TMRA_IDX_CONV_CTRL ||
       idx == `TMRA_IDX_ENABLES_ONE || idx == `TMRA_IDX_ENABLES_TWO);

   // Read multiplexer
   always @* begin
      case (idx)
         `TMRA_IDX_GLOBAL_CTRL: read_byte = global_interrupt_control;
         `TMRA_IDX_FLAGS_ONE: read_byte = peripheral_flags_one;
         `TMRA_IDX_FLAGS_TWO: read_byte = peripheral_flags_two;
         `TMRA_IDX_COUNT_LOW: read_byte = count_low_byte;
         `TMRA_IDX_COUNT_HIGH: read_byte = count_high_byte;
         `TMRA_IDX_TIMER_CTRL: read_byte = timer_control;
         `TMRA_IDX_CONV_RESULT: read_byte = conversion_result;
         `TMRA_IDX_CONV_CTRL: read_byte = converter_control;
         `TMRA_IDX_ENABLES_ONE: read_byte = peripheral_enables_one;
         `TMRA_IDX_ENABLES_TWO: read_byte = peripheral_enables_two;
         default: read_byte = `TMRA_RST_BYTE;
      endcase
   end

   // Bus handshake: one wait cycle so read data comes from a flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else if (access && !pready) begin
         pready <= 1'b1;
         pslverr <= ~mapped;
         prdata <= mapped ? {24'h0, read_byte} : 32'h0;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // External clock edge; the pin is taken as synchronous
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_clk_q <= 1'b0;
      end else begin
         ext_clk_q <= ext_clk_pin;
      end
   end

   assign wr_low = wr && idx == `TMRA_IDX_COUNT_LOW;
   assign wr_high = wr && idx == `TMRA_IDX_COUNT_HIGH;
   assign count_wr = wr_low | wr_high;
   assign src_tick = timer_control[`TMRA_TC_ON] &
      (timer_control[`TMRA_TC_EXT_SRC] ? (ext_clk_pin & ~ext_clk_q) : 1'b1);

   tmra_prescale u_prescale (
      .pclk(pclk),
      .presetn(presetn),
      .clear(count_wr),
      .tick_in(src_tick),
      .ratio(timer_control[`TMRA_TC_PS_HI:`TMRA_TC_PS_LO]),
      .tick_out(pre_tick)
   );

   tmra_trigger u_trigger (
      .cmp_match({cmp_second_match, cmp_first_match}),
      .cmp_mode({cmp_second_mode, cmp_first_mode}),
      .conv_enable(converter_control[`TMRA_CC_ENABLE]),
      .special(special),
      .conv_start(start_req)
   );

   assign trig_reset = special[0] | special[1];
   assign count = {count_high_byte, count_low_byte};
   assign count_inc = {1'b0, count} + 17'h1;

   // Count pair: no reset term, so neither presetn nor other_reset touches it; only the trigger clears it
   always @(posedge pclk) begin
      if (count_wr) begin
         // Write beats trigger and increment
         if (wr_low) begin
            count_low_byte <= pwdata[7:0];
         end
         if (wr_high) begin
            count_high_byte <= pwdata[7:0];
         end
      end else if (trig_reset) begin
         count_low_byte <= `TMRA_RST_BYTE;
         count_high_byte <= `TMRA_RST_BYTE;
      end else if (pre_tick) begin
         count_low_byte <= count_inc[7:0];
         count_high_byte <= count_inc[15:8];
      end
   end

   // Timer control: only power-on / brown-out reset clears it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control <= `TMRA_RST_BYTE;
      end else if (wr && idx == `TMRA_IDX_TIMER_CTRL) begin
         timer_control <= pwdata[7:0] & `TMRA_TC_MASK;
      end
   end

   // Flag next values; a set in the clearing cycle survives
   always @* begin
      next_flags_one = peripheral_flags_one;
      next_flags_two = peripheral_flags_two;
      if (wr && idx == `TMRA_IDX_FLAGS_ONE) begin
         next_flags_one = pwdata[7:0];
      end else if (rd && idx == `TMRA_IDX_FLAGS_ONE) begin
         next_flags_one = `TMRA_RST_BYTE;
      end
      if (wr && idx == `TMRA_IDX_FLAGS_TWO) begin
         next_flags_two = pwdata[7:0] & `TMRA_F2_MASK;
      end else if (rd && idx == `TMRA_IDX_FLAGS_TWO) begin
         next_flags_two = `TMRA_RST_BYTE;
      end
      // Overflow only from counting, never from a trigger reset
      if (pre_tick && !count_wr && !trig_reset && count_inc[16]) begin
         next_flags_one[`TMRA_F1_OVERFLOW] = 1'b1;
      end
      if (special[0]) begin
         next_flags_one[`TMRA_F1_CMP_FIRST] = 1'b1;
      end
      if (conv_done) begin
         next_flags_one[`TMRA_F1_CONV_DONE] = 1'b1;
      end
      if (special[1]) begin
         next_flags_two[`TMRA_F2_CMP_SECOND] = 1'b1;
      end
   end

   // Converter control next value; trigger start wins over done
   always @* begin
      next_conv_ctrl = converter_control;
      if (wr && idx == `TMRA_IDX_CONV_CTRL) begin
         next_conv_ctrl = pwdata[7:0] & `TMRA_CC_MASK;
      end
      if (conv_done) begin
         next_conv_ctrl[`TMRA_CC_GO] = 1'b0;
      end
      if (start_req) begin
         next_conv_ctrl[`TMRA_CC_GO] = 1'b1;
      end
   end

   // Registers cleared by every reset, except bit 0 of global control on other_reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_interrupt_control <= `TMRA_RST_BYTE;
         peripheral_flags_one <= `TMRA_RST_BYTE;
         peripheral_flags_two <= `TMRA_RST_BYTE;
         converter_control <= `TMRA_RST_BYTE;
         peripheral_enables_one <= `TMRA_RST_BYTE;
         peripheral_enables_two <= `TMRA_RST_BYTE;
      end else if (other_reset) begin
         // Bit 0 of global control keeps its value on other resets
         global_interrupt_control <= {7'h0, global_interrupt_control[0]};
         peripheral_flags_one <= `TMRA_RST_BYTE;
         peripheral_flags_two <= `TMRA_RST_BYTE;
         converter_control <= `TMRA_RST_BYTE;
         peripheral_enables_one <= `TMRA_RST_BYTE;
         peripheral_enables_two <= `TMRA_RST_BYTE;
      end else begin
         if (wr && idx == `TMRA_IDX_GLOBAL_CTRL) begin
            global_interrupt_control <= pwdata[7:0];
         end
         if (wr && idx == `TMRA_IDX_ENABLES_ONE) begin
            peripheral_enables_one <= pwdata[7:0];
         end
         if (wr && idx == `TMRA_IDX_ENABLES_TWO) begin
            peripheral_enables_two <= pwdata[7:0] & `TMRA_F2_MASK;
         end
         peripheral_flags_one <= next_flags_one;
         peripheral_flags_two <= next_flags_two;
         converter_control <= next_conv_ctrl;
      end
   end

   // Conversion result: unchanged by reset, loaded when converter finishes
   always @(posedge pclk) begin
      if (conv_done) begin
         conversion_result <= conv_data;
      end
   end

   // Converter side outputs, all registered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_start <= 1'b0;
         conv_enable <= 1'b0;
         conv_channel <= 3'h0;
         conv_clock_sel <= 2'h0;
      end else begin
         // Channel and acquisition time are software's job before the trigger
         conv_start <= start_req & ~other_reset;
         conv_enable <= next_conv_ctrl[`TMRA_CC_ENABLE] & ~other_reset;
         conv_channel <= other_reset ? 3'h0 : next_conv_ctrl[5:3];
         conv_clock_sel <= other_reset ? 2'h0 : next_conv_ctrl[7:6];
      end
   end

   // Interrupt: level, gated by global and peripheral enables
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= global_interrupt_control[`TMRA_GC_GLOBAL] &
            global_interrupt_control[`TMRA_GC_PERIPH] &
            (|(peripheral_flags_one & peripheral_enables_one) |
             |(peripheral_flags_two & peripheral_enables_two));
      end
   end
endmodule // tmra_top

/* tb/tmra_chk.sv */
// Purpose: port checker for the timer block
// Assumes: fixed three-cycle APB transfer
// Notes: bound into the top at the foot
`timescale 1ns/1ns
module tmra_chk (
   // Clock and resets
   input wire pclk,
   input wire presetn,
   input wire other_reset,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Trigger and converter
   input wire cmp_second_match,
   input wire [3:0] cmp_second_mode,
   input wire conv_start,
   input wire conv_enable,
   input wire [2:0] conv_channel
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Causes decoded from the port side
   wire wr_cc = pready && psel && pwrite && paddr == 12'h07c;
   wire trig = cmp_second_match && cmp_second_mode == 4'hb && conv_enable;
   chk_start_follow: assert property (trig |=> conv_start)
      else $error("no start after trigger");
   chk_start_cause: assert property (conv_start |-> $past(trig))
      else $error("start without trigger");
   chk_ready_time: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("ready not on third cycle");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
   chk_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("data on refused access");
   chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   // Only a register write or a soft reset may move these
   chk_enable_write: assert property (
      $changed(conv_enable) |-> $past(wr_cc) || $past(other_reset))
      else $error("enable moved alone");
   chk_chan_write: assert property (
      $changed(conv_channel) |-> $past(wr_cc) || $past(other_reset))
      else $error("channel moved alone");
   // Main scenarios
   cover property (conv_start);
   cover property (pready && pslverr);
   cover property (trig);
endmodule // tmra_chk

bind tmra_top tmra_chk tmra_chk_inst (.pclk, .presetn, .other_reset, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .pslverr, .cmp_second_match, .cmp_second_mode, .conv_start,
   .conv_enable, .conv_channel);

/* tb/tmra_partner.sv */
// Purpose: compare units and converter beside the timer block
// Assumes: fire is called right after a rising edge
// Notes: conversion lag set by the bench, prompt or slow
`timescale 1ns/1ns
module tmra_partner (
   // Clock
   input wire pclk,
   // Compare units
   output logic cmp_first_match = 1'b0,
   output logic [3:0] cmp_first_mode = 4'h0,
   output logic cmp_second_match = 1'b0,
   output logic [3:0] cmp_second_mode = 4'h0,
   // Converter
   input wire conv_start,
   input wire [2:0] conv_channel,
   output logic conv_done = 1'b0,
   output logic [7:0] conv_data = 8'h55
);
   int lag = 20;
   int starts = 0;
   int left = -1;
   // One-cycle match pulse from either unit
   task automatic fire(input logic second);
      if (second)
         cmp_second_match <= 1'b1;
      else
         cmp_first_match <= 1'b1;
      @(posedge pclk);
      cmp_first_match <= 1'b0;
      cmp_second_match <= 1'b0;
   endtask
   // Result lag + 1 edges after the start is seen; data toggles while not valid
   // Each signal assigned once per edge; the count idles at -1
   always @(posedge pclk) begin
      if (conv_start) begin
         starts <= starts + 1;
         left <= lag;
      end else if (left >= 0) begin
         left <= left - 1;
      end
      conv_done <= !conv_start && left == 0;
      conv_data <= (!conv_start && left == 0) ? {5'h18, conv_channel} : ~conv_data;
   end
endmodule // tmra_partner

/* tb/test_tmra_top.sv */
// Purpose: self-checking bench for the timer block
// Assumes: hand-over APB timing, partner model on the far side
// Notes: external clock pin held low; prescaler clear seen through count timing
`timescale 1ns/1ns
module test_tmra_top;
   logic pclk, presetn, other_reset, psel, penable, pwrite, pready, pslverr, err;
   logic cmp_first_match, cmp_second_match, conv_start, conv_enable, conv_done, irq;
   logic [3:0] cmp_first_mode, cmp_second_mode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] conv_data, rd;
   logic [2:0] conv_channel;
   logic [1:0] conv_clock_sel;
   int err_total = 0;
   int tests_run = 0;
   int cycles = 0;
   tmra_top tmra_top_inst (.pclk, .presetn, .other_reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .ext_clk_pin(1'b0), .cmp_first_match,
      .cmp_first_mode, .cmp_second_match, .cmp_second_mode, .conv_done, .conv_data,
      .conv_start, .conv_enable, .conv_channel, .conv_clock_sel, .irq);
   tmra_partner tmra_partner_inst (.pclk, .cmp_first_match, .cmp_first_mode,
      .cmp_second_match, .cmp_second_mode, .conv_start, .conv_channel, .conv_done, .conv_data);
   // Clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Hang guard, far above the few hundred cycles used
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One APB transfer in the low byte lane, idle edge after it
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd_count(output logic [15:0] c);
      apb(1'b0, 10'h00e, 8'h00);
      c[7:0] = rd;
      apb(1'b0, 10'h00f, 8'h00);
      c[15:8] = rd;
   endtask
   task automatic wr_count(input logic [15:0] c);
      apb(1'b1, 10'h00e, c[7:0]);
      apb(1'b1, 10'h00f, c[15:8]);
   endtask
   // Power-on values and an unmapped index
   task automatic t_reset();
      logic [9:0] idx[6] = '{10'h00c, 10'h00d, 10'h010, 10'h01f, 10'h08c, 10'h08d};
      foreach (idx[i]) begin
         apb(1'b0, idx[i], 8'h00);
         check("reset value", rd, 8'h00);
      end
      apb(1'b0, 10'h020, 8'h00);
      check("unmapped", err, 1'b1);
   endtask
   // Count survives both resets; control survives only the soft one
   task automatic t_resets();
      logic [15:0] c;
      apb(1'b1, 10'h010, 8'h30);
      wr_count(16'ha55a);
      other_reset <= 1'b1;
      @(posedge pclk);
      other_reset <= 1'b0;
      @(posedge pclk);
      apb(1'b0, 10'h010, 8'h00);
      check("control soft", rd, 8'h30);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 10'h010, 8'h00);
      check("control power", rd, 8'h00);
      rd_count(c);
      check("count kept", c, 16'ha55a);
   endtask
   // One match: unit, converter enable and mode vary
   task automatic t_trig(input logic second, en, input logic [3:0] mode);
      logic [15:0] c;
      logic hit, st;
      int s;
      hit = (mode == 4'hb);
      st = second && hit && en;
      s = tmra_partner_inst.starts;
      tmra_partner_inst.cmp_first_mode <= mode;
      tmra_partner_inst.cmp_second_mode <= mode;
      apb(1'b1, 10'h01f, {5'b01101, 2'b00, en});
      wr_count(16'h1234);
      apb(1'b1, 10'h00c, 8'h00);
      apb(1'b1, 10'h00d, 8'h00);
      tmra_partner_inst.fire(second);
      apb(1'b0, 10'h01f, 8'h00);
      check("go", rd[2], st);
      check("clock select", conv_clock_sel, 2'h1);
      rd_count(c);
      check("count", c, hit ? 16'h0 : 16'h1234);
      repeat (24) @(posedge pclk);
      check("starts", 16'(tmra_partner_inst.starts - s), st);
      apb(1'b0, 10'h00d, 8'h00);
      check("second flag", rd[0], second && hit);
      apb(1'b0, 10'h00c, 8'h00);
      check("first flags", rd, {1'b0, st, 3'b0, !second && hit, 2'b0});
      apb(1'b0, 10'h01e, 8'h00);
      if (st)
         check("result", rd, 8'hc5);
   endtask
   // Count write on the trigger edge, prompt converter
   task automatic t_race();
      logic [15:0] c;
      tmra_partner_inst.lag = 2;
      fork
         apb(1'b1, 10'h00e, 8'h77);
         begin
            repeat (2) @(posedge pclk);
            tmra_partner_inst.fire(1'b1);
         end
      join
      rd_count(c);
      check("write wins", c[7:0], 8'h77);
   endtask
   // Count write restarts the 1:8 prescaler; step lands exactly eight edges on
   task automatic t_pre();
      apb(1'b1, 10'h010, 8'h31);
      for (int k = 5; k < 7; k++) begin
         apb(1'b1, 10'h00e, 8'h00);
         repeat (k) @(posedge pclk);
         apb(1'b0, 10'h00e, 8'h00);
         check("prescale", rd, 16'(k - 5));
      end
      apb(1'b1, 10'h010, 8'h00);
   endtask
   // Rollover sets the flag; mask and read-clear drop the line
   task automatic t_ovf();
      apb(1'b1, 10'h08c, 8'h01);
      apb(1'b1, 10'h00b, 8'hc0);
      wr_count(16'hfffe);
      apb(1'b1, 10'h00c, 8'h00);
      apb(1'b1, 10'h010, 8'h01);
      apb(1'b1, 10'h010, 8'h00);
      check("irq set", irq, 1'b1);
      apb(1'b1, 10'h08c, 8'h00);
      repeat (2) @(posedge pclk);
      check("irq masked", irq, 1'b0);
      apb(1'b1, 10'h08c, 8'h01);
      repeat (2) @(posedge pclk);
      check("irq unmasked", irq, 1'b1);
      apb(1'b0, 10'h00c, 8'h00);
      check("overflow flag", rd[0], 1'b1);
      repeat (2) @(posedge pclk);
      check("irq cleared", irq, 1'b0);
   endtask
   // Main sequence
   initial begin
      presetn = 1'b0;
      other_reset = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_resets();
      t_trig(1'b0, 1'b1, 4'hb);
      t_trig(1'b1, 1'b1, 4'ha);
      t_trig(1'b1, 1'b0, 4'hb);
      t_trig(1'b1, 1'b1, 4'hb);
      t_race();
      t_pre();
      t_ovf();
      end_sim();
   end
endmodule // test_tmra_top
